//--- motor_ctrl_map.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * motor controller protection and status register bank.
 * Assumes it is included by bare name wherever these constants are needed.
 */
`ifndef MOTOR_CTRL_MAP_SVH
`define MOTOR_CTRL_MAP_SVH

`define OFS_WDT_CTRL      8'h0b
`define OFS_DUTY_CMD      8'h0c
`define OFS_AREF_CMD      8'h0d
`define OFS_ANGLE_RB      8'h20
`define OFS_SUPPLY_RB     8'h21
`define OFS_FEEDBACK_RB   8'h22
`define OFS_TEMP_RB       8'h23
`define OFS_HP_HIGH       8'h26
`define OFS_HP_LOW        8'h27
`define OFS_STATUS        8'h28

`define CTRL_PIN_LATCH    7
`define CTRL_OT_LATCH     6
`define CTRL_CRC_EN       4
`define CTRL_WATCHDOG_EN       3
`define CTRL_WDT_CLR      2
`define CTRL_WDT_PER      1:0

`define ST_OVERTEMP       7
`define ST_OVERLOAD       6
`define ST_PIN_FAULT      5
`define ST_OVERVOLT       4
`define ST_HALL_ERR       3
`define ST_DIR_ERR        2
`define ST_WDT_TIMEOUT    1
`define ST_SHORT          0

`define REG_RESET_VAL     8'h00
`define WDT_BASE_MS       250
`define WDT_REF_FSYS_KHZ  1280
`define HP_DIV_RANGE0     4'h4
`define HP_DIV_RANGE1     4'h8
`define HALL_ALL_LOW      3'h0
`define HALL_ALL_HIGH     3'h7

`endif

//--- motor_ctrl_pkg.sv
/*
 * Types shared by the motor controller register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package motor_ctrl_pkg;

    typedef struct packed {
        logic       clk_res_open;   // Clock-resistor pin open.
        logic       temp_open;      // Temperature pin open.
        logic       clk_res_short;  // Clock-resistor pin shorted.
        logic       overtemp;       // Temperature pin below trip level.
        logic       overload;       // Overload over-current tripped.
        logic       overvoltage;    // Supply sense above trip level.
        logic       short_cur;      // Current input above short level.
    } fault_cond_s;

    typedef struct packed {
        logic [4:0] angle;
        logic [4:0] supply;
        logic [4:0] feedback;
        logic [4:0] temperature;
    } adc_codes_s;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } reg_req_s;

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  duty;
        logic [7:0]  aref;
        logic [7:0]  rdata;
        logic [7:0]  status;
        logic [7:0]  duty_out;
        logic [7:0]  aref_out;
        logic        pwm_off;
        logic        pin_latch;
        logic        ot_latch;
        logic        fs_pin_q;
        logic        fs_bit_q;
        logic [2:0]  hall_q;
        logic        dir_err;
        logic [23:0] wdt_cnt;
        logic        wdt_to;
        logic [2:0]  pre;
        logic [15:0] hp_cnt;
        logic [15:0] hp_per;
        logic        hp_frozen;
    } state_s;

endpackage : motor_ctrl_pkg

//--- motor_ctrl_protect_status_regs.sv
/*
 * Protection latch, watchdog, duty/reference substitute, analog readback,
 * Hall period and fault status register bank of a brushless motor
 * controller.
 * Assumes the serial framing outside delivers one-cycle read and write
 * strobes with address and data, and that all inputs share sys_clk_i.
 */
// Behaviour
// - Pin fault unlatched when latch select clear.
// - Latched pin fault holds PWM off until release.
// - Open on both pins, short on clock pin.
// - Overtemp unlatched when latch enable clear.
// - Latched overtemp holds PWM off until release.
// - Control bit 4 enables serial CRC.
// - Control bit 3 enables the watchdog.
// - Period field picks four doubling timeouts.
// - Duty register replaces duty pin when selected.
// - Reference register replaces reference pin when selected.
// - Read-only registers at 0x20 to 0x28.
// - Readbacks carry 5-bit codes, upper bits zero.
// - Sixteen-bit counter measures Hall pattern intervals.
// - Counter clock divided by 4, 8 or 1.
// - High read freezes period until low read.
// - Status bit 7 shows over-temperature trip.
// - Status bits 6, 5 show overload, pin fault.
// - Status bit 4 shows over-voltage trip.
// - Status bit 3 shows illegal Hall pattern.
// - Status bit 2 shows Hall direction mismatch.
// - Status bit 1 shows watchdog timeout.
// - Status bit 0 shows short-circuit trip.
`include "motor_ctrl_map.svh"

module motor_ctrl_protect_status_regs
    import motor_ctrl_pkg::*;
#(
    parameter int WDT_BASE_CYCLES = `WDT_BASE_MS * `WDT_REF_FSYS_KHZ
) (
    input  wire logic        sys_clk_i,            // System clock.
    input  wire logic        rst_n_i,              // Async reset, low.
    input  wire reg_req_s    reg_req_i,            // Register strobes.
    output logic      [7:0]  reg_rdata_o,          // Read data.
    input  wire fault_cond_s fault_i,              // Comparator levels.
    input  wire adc_codes_s  adc_i,                // Converter codes.
    input  wire logic        free_stop_i,          // Free/stop pin.
    input  wire logic        free_stop_bit_i,      // Free/stop ctrl bit.
    input  wire logic        duty_source_sel_i,    // Use duty register.
    input  wire logic        reference_source_sel_i, // Use ref register.
    input  wire logic [1:0]  speed_range_sel_i,    // Hall count range.
    input  wire logic [2:0]  hall_inputs_i,        // Hall pattern.
    input  wire logic        seq_forward_i,        // Sequencer direction.
    input  wire logic [7:0]  duty_pin_i,           // Duty pin code.
    input  wire logic [7:0]  amp_reference_pin_i,  // Reference pin code.
    output logic      [7:0]  duty_cmd_o,           // PWM width command.
    output logic      [7:0]  amp_reference_o,      // Amplifier reference.
    output logic             pwm_off_o,            // All PWM outputs off.
    output logic             crc_en_o,             // Serial CRC enable.
    output logic      [7:0]  fault_status_o        // Status byte.
);

    if (WDT_BASE_CYCLES < 1 || WDT_BASE_CYCLES > 24'h1fffff) begin : g_chk
        $error("WDT_BASE_CYCLES must fit a 24-bit count after x8");
    end

    // Position of a legal Hall code in the forward commutation order.
    function automatic logic [2:0] hall_pos(input logic [2:0] code);
        unique case (code)
            3'h1:    hall_pos = 3'h0;
            3'h3:    hall_pos = 3'h1;
            3'h2:    hall_pos = 3'h2;
            3'h6:    hall_pos = 3'h3;
            3'h4:    hall_pos = 3'h4;
            3'h5:    hall_pos = 3'h5;
            default: hall_pos = 3'h7;
        endcase
    endfunction : hall_pos

    function automatic logic [2:0] hall_succ(input logic [2:0] pos);
        hall_succ = (pos == 3'h5) ? 3'h0 : pos + 3'h1;
    endfunction : hall_succ

    function automatic logic [23:0] wdt_limit(input logic [1:0] sel);
        wdt_limit = 24'(WDT_BASE_CYCLES) << sel;
    endfunction : wdt_limit

    state_s st_reg;
    state_s st_next;

    logic        pin_fault;
    logic        release_ev;
    logic        wdt_clear;
    logic        hp_tick;
    logic        hall_change;
    logic        hall_illegal;
    logic [2:0]  pos_old;
    logic [2:0]  pos_new;
    logic [23:0] limit;
    logic        rd_high;
    logic        rd_low;

    always_comb begin
        st_next = st_reg;
        pin_fault = fault_i.clk_res_open | fault_i.temp_open
                  | fault_i.clk_res_short;
        // Either a falling free/stop pin or a 1-then-0 control bit.
        release_ev = (st_reg.fs_pin_q & ~free_stop_i)
                   | (st_reg.fs_bit_q & ~free_stop_bit_i);
        wdt_clear = reg_req_i.wr && reg_req_i.addr == `OFS_WDT_CTRL
                    && reg_req_i.wdata[`CTRL_WDT_CLR];
        rd_high = reg_req_i.rd && reg_req_i.addr == `OFS_HP_HIGH;
        rd_low = reg_req_i.rd && reg_req_i.addr == `OFS_HP_LOW;
        limit = wdt_limit(st_reg.ctrl[`CTRL_WDT_PER]);
        st_next.fs_pin_q = free_stop_i;
        st_next.fs_bit_q = free_stop_bit_i;

        // The clear bit is an action, so it is never stored.
        if (reg_req_i.wr) begin
            unique case (reg_req_i.addr)
                `OFS_WDT_CTRL: begin
                    st_next.ctrl = reg_req_i.wdata;
                    st_next.ctrl[`CTRL_WDT_CLR] = 1'b0;
                end
                `OFS_DUTY_CMD: st_next.duty = reg_req_i.wdata;
                `OFS_AREF_CMD: st_next.aref = reg_req_i.wdata;
                default: ;
            endcase
        end

        // A fault present in the release cycle keeps the latch set.
        if (!st_reg.ctrl[`CTRL_PIN_LATCH]) begin
            st_next.pin_latch = 1'b0;
        end else if (pin_fault) begin
            st_next.pin_latch = 1'b1;
        end else if (release_ev) begin
            st_next.pin_latch = 1'b0;
        end
        if (!st_reg.ctrl[`CTRL_OT_LATCH]) begin
            st_next.ot_latch = 1'b0;
        end else if (fault_i.overtemp) begin
            st_next.ot_latch = 1'b1;
        end else if (release_ev) begin
            st_next.ot_latch = 1'b0;
        end
        st_next.pwm_off = pin_fault | st_reg.pin_latch
                        | fault_i.overtemp | st_reg.ot_latch;

        st_next.duty_out = duty_source_sel_i ? st_reg.duty
                                             : duty_pin_i;
        st_next.aref_out = reference_source_sel_i ? st_reg.aref
                                                  : amp_reference_pin_i;

        // Timeout holds the count until software clears or disables.
        if (!st_reg.ctrl[`CTRL_WATCHDOG_EN]) begin
            st_next.wdt_cnt = '0;
        end else if (wdt_clear) begin
            st_next.wdt_cnt = '0;
            st_next.wdt_to = 1'b0;
        end else if (st_reg.wdt_cnt >= limit - 24'h1) begin
            st_next.wdt_to = 1'b1;
        end else begin
            st_next.wdt_cnt = st_reg.wdt_cnt + 24'h1;
        end

        hp_tick = speed_range_sel_i[1] ? 1'b1
                : ({1'b0, st_reg.pre}
                   == (speed_range_sel_i[0] ? `HP_DIV_RANGE1
                                            : `HP_DIV_RANGE0)
                   - 4'h1);
        st_next.pre = hp_tick ? 3'h0 : st_reg.pre + 3'h1;

        hall_change = hall_inputs_i != st_reg.hall_q;
        hall_illegal = hall_inputs_i == `HALL_ALL_LOW
                     || hall_inputs_i == `HALL_ALL_HIGH;
        pos_old = hall_pos(st_reg.hall_q);
        pos_new = hall_pos(hall_inputs_i);
        st_next.hall_q = hall_inputs_i;
        if (hall_change && pos_old != 3'h7 && pos_new != 3'h7) begin
            if (pos_new == hall_succ(pos_old)) begin
                st_next.dir_err = ~seq_forward_i;
            end else if (pos_old == hall_succ(pos_new)) begin
                st_next.dir_err = seq_forward_i;
            end
        end

        // Counting stays parked at zero while software owns the value. The
        // high-byte read cycle counts as frozen too, so a Hall edge landing
        // on it cannot hand out bytes from two different periods.
        if (st_reg.hp_frozen || rd_high) begin
            st_next.hp_cnt = '0;
        end else if (hall_change) begin
            st_next.hp_per = st_reg.hp_cnt;
            st_next.hp_cnt = '0;
        end else if (hp_tick && st_reg.hp_cnt != 16'hffff) begin
            st_next.hp_cnt = st_reg.hp_cnt + 16'h1;
        end

        if (rd_high) begin
            st_next.hp_frozen = 1'b1;
        end else if (rd_low) begin
            st_next.hp_frozen = 1'b0;
        end

        st_next.status = '0;
        st_next.status[`ST_OVERTEMP] = fault_i.overtemp
                                     | st_reg.ot_latch;
        st_next.status[`ST_OVERLOAD] = fault_i.overload;
        st_next.status[`ST_PIN_FAULT] = pin_fault
                                      | st_reg.pin_latch;
        st_next.status[`ST_OVERVOLT] = fault_i.overvoltage;
        st_next.status[`ST_HALL_ERR] = hall_illegal;
        st_next.status[`ST_DIR_ERR] = st_reg.dir_err;
        st_next.status[`ST_WDT_TIMEOUT] = st_reg.wdt_to;
        st_next.status[`ST_SHORT] = fault_i.short_cur;

        if (reg_req_i.rd) begin
            unique case (reg_req_i.addr)
                `OFS_WDT_CTRL:    st_next.rdata = st_reg.ctrl;
                `OFS_DUTY_CMD:    st_next.rdata = st_reg.duty;
                `OFS_AREF_CMD:    st_next.rdata = st_reg.aref;
                `OFS_ANGLE_RB:    st_next.rdata = {3'h0, adc_i.angle};
                `OFS_SUPPLY_RB:   st_next.rdata = {3'h0, adc_i.supply};
                `OFS_FEEDBACK_RB: st_next.rdata = {3'h0, adc_i.feedback};
                `OFS_TEMP_RB:     st_next.rdata = {3'h0, adc_i.temperature};
                `OFS_HP_HIGH:     st_next.rdata = st_reg.hp_per[15:8];
                `OFS_HP_LOW:      st_next.rdata = st_reg.hp_per[7:0];
                `OFS_STATUS:      st_next.rdata = st_reg.status;
                default:          st_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_o = st_reg.rdata;
    assign duty_cmd_o = st_reg.duty_out;
    assign amp_reference_o = st_reg.aref_out;
    assign pwm_off_o = st_reg.pwm_off;
    assign crc_en_o = st_reg.ctrl[`CTRL_CRC_EN];
    assign fault_status_o = st_reg.status;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    pin_nolatch_a: assert property (
        !st_reg.ctrl[`CTRL_PIN_LATCH] && !pin_fault
        && !fault_i.overtemp && !st_reg.ot_latch |=> !pwm_off_o)
        else $error("PWM held off without any fault");
    pin_latch_a: assert property (
        st_reg.ctrl[`CTRL_PIN_LATCH] && pin_fault |=> ##1 pwm_off_o)
        else $error("Latched pin fault did not stop PWM");
    pin_hold_a: assert property (
        st_reg.pin_latch && st_reg.ctrl[`CTRL_PIN_LATCH] && !release_ev
        |=> st_reg.pin_latch)
        else $error("Pin fault latch dropped without release");
    ot_latch_a: assert property (
        st_reg.ctrl[`CTRL_OT_LATCH] && fault_i.overtemp
        ##1 !release_ev && st_reg.ctrl[`CTRL_OT_LATCH] |=> pwm_off_o)
        else $error("Latched overtemp did not hold PWM off");
    ot_nolatch_a: assert property (
        !st_reg.ctrl[`CTRL_OT_LATCH] |=> !st_reg.ot_latch)
        else $error("Overtemp latched while latching disabled");
    crc_write_a: assert property (
        reg_req_i.wr && reg_req_i.addr == `OFS_WDT_CTRL
        |=> crc_en_o == $past(reg_req_i.wdata[`CTRL_CRC_EN]))
        else $error("CRC enable did not follow control write");
    wdt_off_a: assert property (
        !st_reg.ctrl[`CTRL_WATCHDOG_EN] |=> st_reg.wdt_cnt == 24'h0)
        else $error("Watchdog counted while disabled");
    wdt_period_a: assert property (
        $rose(st_reg.wdt_to) |-> $past(st_reg.wdt_cnt) == $past(limit) - 1)
        else $error("Watchdog timed out at the wrong count");
    wdt_clear_a: assert property (
        wdt_clear && st_reg.ctrl[`CTRL_WATCHDOG_EN]
        |=> st_reg.wdt_cnt == 24'h0 && !st_reg.wdt_to)
        else $error("Watchdog clear did not restart the count");
    duty_sel_a: assert property (
        duty_source_sel_i |=> duty_cmd_o == $past(st_reg.duty))
        else $error("Duty register not used when selected");
    hp_freeze_a: assert property (
        st_reg.hp_frozen |=> $stable(st_reg.hp_per))
        else $error("Hall period changed while frozen");
    hall_err_a: assert property (
        hall_illegal |=> fault_status_o[`ST_HALL_ERR])
        else $error("Illegal Hall pattern not reported");
    ro_zero_a: assert property (
        reg_req_i.rd && reg_req_i.addr == `OFS_TEMP_RB
        |=> reg_rdata_o[7:5] == 3'h0)
        else $error("Readback upper bits not zero");

    // The checks below tie status bits 7, 6, 4, 1 and 0 and both substitute
    // outputs to the input that drives them, one register stage later.
    aref_sel_a: assert property (
        reference_source_sel_i |=> amp_reference_o == $past(st_reg.aref))
        else $error("Reference register not used when selected");

    duty_pin_a: assert property (
        !duty_source_sel_i |=> duty_cmd_o == $past(duty_pin_i))
        else $error("Duty pin not used when deselected");

    pin_open_a: assert property (
        fault_i.clk_res_open || fault_i.temp_open
        || fault_i.clk_res_short |=> pwm_off_o)
        else $error("Open or short pin did not stop PWM");

    ot_hold_a: assert property (
        st_reg.ot_latch && st_reg.ctrl[`CTRL_OT_LATCH] && !release_ev
        |=> st_reg.ot_latch)
        else $error("Overtemp latch dropped without release");

    ot_status_a: assert property (
        fault_i.overtemp |=> fault_status_o[`ST_OVERTEMP])
        else $error("Overtemp not reported in status");

    overload_a: assert property (
        fault_i.overload |=> fault_status_o[`ST_OVERLOAD])
        else $error("Overload not reported in status");

    overvolt_a: assert property (
        fault_i.overvoltage |=> fault_status_o[`ST_OVERVOLT])
        else $error("Over-voltage not reported in status");

    short_flag_a: assert property (
        fault_i.short_cur |=> fault_status_o[`ST_SHORT])
        else $error("Short circuit not reported in status");

    wdt_flag_a: assert property (
        $rose(st_reg.wdt_to) |=> fault_status_o[`ST_WDT_TIMEOUT])
        else $error("Watchdog timeout not reported in status");

    hp_capture_a: assert property (
        hall_change && !st_reg.hp_frozen && !rd_high
        |=> st_reg.hp_per == $past(st_reg.hp_cnt))
        else $error("Hall period not captured on pattern change");

    hp_divide_a: assert property (
        !speed_range_sel_i[1] && hp_tick ##1 !speed_range_sel_i[1]
        |-> !hp_tick)
        else $error("Divided Hall tick came on consecutive cycles");

    hp_park_a: assert property (
        st_reg.hp_frozen |=> st_reg.hp_cnt == 16'h0)
        else $error("Hall counter ran while period frozen");

    ro_write_a: assert property (
        reg_req_i.wr && reg_req_i.addr[7:4] == 4'h2
        |=> $stable(st_reg.ctrl) && $stable(st_reg.duty)
            && $stable(st_reg.aref))
        else $error("Write to read-only address changed a register");

    reserved_a: assert property (
        reg_req_i.rd && (reg_req_i.addr == 8'h24
                         || reg_req_i.addr == 8'h25)
        |=> reg_rdata_o == 8'h00)
        else $error("Reserved address did not read zero");

    dir_err_a: assert property (
        hall_change && pos_old != 3'h7 && pos_new == hall_succ(pos_old)
        |=> st_reg.dir_err == !$past(seq_forward_i))
        else $error("Direction flag wrong after a forward step");

    // Covers mark the scenarios that the bench must reach at least once.
    latch_release_c: cover property (
        st_reg.pin_latch ##1 !st_reg.pin_latch);
    wdt_timeout_c: cover property ($rose(st_reg.wdt_to));
    freeze_cycle_c: cover property (rd_high ##[1:20] rd_low);
    dir_err_c: cover property ($rose(st_reg.dir_err));
    hall_err_c: cover property ($rose(fault_status_o[`ST_HALL_ERR]));

endmodule : motor_ctrl_protect_status_regs

//--- motor_ctrl_protect_status_regs_bench.sv
/*
 * Self-checking bench of the protection and status register bank.
 * Assumes reg_host_model drives the register strobes.
 */
`include "motor_ctrl_map.svh"

module motor_ctrl_protect_status_regs_bench
    import motor_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int WDT_BASE = 8;
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wd;
        logic [7:0] exp;
    } row_s;

    logic        clk, rst_n, fs_pin, fs_bit, duty_sel, ref_sel, fwd_dir;
    logic        pwm_off, crc_en;
    logic [1:0]  range;
    logic [2:0]  hall;
    logic [7:0]  duty_pin, ref_pin, rdata, duty_cmd, aref, status, d, hi;
    logic [15:0] p;
    reg_req_s    req;
    fault_cond_s fault;
    adc_codes_s  adc;
    int          mismatches, total_checks, hidx, n, lim;
    int          sbit [7] = '{5, 5, 5, 7, 6, 4, 0};
    logic [2:0]  fwd [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    logic [1:0]  rng [3] = '{2'b00, 2'b01, 2'b10};
    int          gap [3] = '{40, 80, 20};
    int          ep [3] = '{10, 10, 20};
    row_s        rows [14] = '{
        '{1'b0, 8'h0b, 8'h00, 8'h00}, '{1'b0, 8'h0c, 8'h00, 8'h00},
        '{1'b0, 8'h0d, 8'h00, 8'h00}, '{1'b0, 8'h20, 8'h00, 8'h15},
        '{1'b0, 8'h21, 8'h00, 8'h0a}, '{1'b0, 8'h22, 8'h00, 8'h1f},
        '{1'b0, 8'h23, 8'h00, 8'h03}, '{1'b0, 8'h24, 8'h00, 8'h00},
        '{1'b0, 8'h25, 8'h00, 8'h00}, '{1'b0, 8'h28, 8'h00, 8'h00},
        '{1'b1, 8'h0c, 8'haa, 8'haa}, '{1'b1, 8'h0d, 8'h55, 8'h55},
        '{1'b1, 8'h20, 8'hff, 8'h15}, '{1'b1, 8'h0b, 8'h14, 8'h10}};

    reg_host_model host (.sys_clk_i(clk), .rdata_i(rdata), .req_o(req));

    motor_ctrl_protect_status_regs #(.WDT_BASE_CYCLES(WDT_BASE)) uut (
        .sys_clk_i(clk), .rst_n_i(rst_n), .reg_req_i(req),
        .reg_rdata_o(rdata), .fault_i(fault), .adc_i(adc),
        .free_stop_i(fs_pin), .free_stop_bit_i(fs_bit),
        .duty_source_sel_i(duty_sel), .reference_source_sel_i(ref_sel),
        .speed_range_sel_i(range), .hall_inputs_i(hall),
        .seq_forward_i(fwd_dir), .duty_pin_i(duty_pin),
        .amp_reference_pin_i(ref_pin), .duty_cmd_o(duty_cmd),
        .amp_reference_o(aref), .pwm_off_o(pwm_off), .crc_en_o(crc_en),
        .fault_status_o(status));

    task automatic wrap_up();
        if (mismatches == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_rng(input logic [15:0] got, input int lo, hi);
        total_checks++;
        if (((got >= lo) && (got <= hi)) !== 1'b1) begin
            mismatches++;
            $display("mismatch at %0t: %h outside %0d..%0d", $time, got,
                     lo, hi);
        end
    endtask : chk_rng

    task automatic wait_cyc(input int c);
        repeat (c) @(posedge clk);
    endtask : wait_cyc

    task automatic hall_step(input logic dir);
        hidx = (hidx + (dir ? 1 : 5)) % 6;
        hall <= fwd[hidx];
    endtask : hall_step

    // Raise one fault kind, drop it, then release any latch by a falling
    // edge of the pin (pin faults) or of the control bit (overtemp).
    task automatic fault_case(input int k, input logic lat);
        host.write_reg(`OFS_WDT_CTRL, lat ? 8'hc0 : 8'h00);
        fault <= fault_cond_s'(7'h40 >> k);
        wait_cyc(3);
        chk(pwm_off, k < 4);
        chk(status[sbit[k]], 1);
        fault <= '0;
        wait_cyc(3);
        chk(pwm_off, lat);
        if (lat) begin
            if (k == 3) fs_bit <= 1'b1;
            else fs_pin <= 1'b1;
            wait_cyc(2);
            fs_bit <= 1'b0;
            fs_pin <= 1'b0;
            wait_cyc(3);
            chk(pwm_off, 0);
        end
    endtask : fault_case

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #300us;
        mismatches++;
        wrap_up();
    end

    initial begin
        rst_n = 1'b0;
        {fs_pin, fs_bit, duty_sel, ref_sel, range} = '0;
        fwd_dir = 1'b1;
        hidx = 0;
        hall = fwd[0];
        fault = '0;
        adc = '{angle: 5'h15, supply: 5'h0a, feedback: 5'h1f,
                temperature: 5'h03};
        duty_pin = 8'h33;
        ref_pin = 8'h44;
        wait_cyc(10);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) host.write_reg(rows[i].addr, rows[i].wd);
            host.read_reg(rows[i].addr, d);
            chk(d, rows[i].exp);
        end
        wait_cyc(1);
        chk(crc_en, 1);
        for (int s = 0; s < 2; s++) begin
            duty_sel <= s[0];
            ref_sel <= s[0];
            wait_cyc(3);
            chk(duty_cmd, s ? 8'haa : 8'h33);
            chk(aref, s ? 8'h55 : 8'h44);
        end
        for (int k = 0; k < 7; k++) fault_case(k, 1'b0);
        for (int k = 0; k < 4; k++) fault_case(k, 1'b1);
        chk(crc_en, 0);
        for (int i = 0; i < 3; i++) begin
            range <= rng[i];
            hall_step(1'b1);
            wait_cyc(gap[i]);
            hall_step(1'b1);
            wait_cyc(3);
            host.read_period(p);
            chk_rng(p, ep[i] - 2, ep[i] + 2);
        end
        hall_step(1'b1);
        wait_cyc(20);
        hall_step(1'b1);
        wait_cyc(3);
        host.read_reg(`OFS_HP_HIGH, hi);
        hall_step(1'b1);
        wait_cyc(50);
        hall_step(1'b1);
        wait_cyc(3);
        host.read_reg(`OFS_HP_LOW, d);
        chk_rng({hi, d}, 18, 22);
        chk(status[2], 0);
        hall_step(1'b0);
        wait_cyc(3);
        chk(status[2], 1);
        hall <= 3'h0;
        wait_cyc(3);
        chk(status[3], 1);
        hall <= 3'h7;
        wait_cyc(3);
        chk(status[3], 1);
        hall <= fwd[hidx];
        wait_cyc(3);
        chk(status[3], 0);
        for (int per = 0; per < 4; per++) begin
            lim = WDT_BASE << per;
            host.write_reg(`OFS_WDT_CTRL, 8'h04);
            host.write_reg(`OFS_WDT_CTRL, 8'h08 | 8'(per));
            wait_cyc(lim / 2);
            host.clear_watchdog(2'(per));
            n = 0;
            while (status[1] !== 1'b1 && n < 300) begin
                @(posedge clk);
                n++;
            end
            chk_rng(n, lim - 2, lim + 3);
        end
        host.write_reg(`OFS_WDT_CTRL, 8'h14);
        wait_cyc(100);
        chk(status[1], 0);
        // A second reset in mid-run must clear the control register too.
        rst_n <= 1'b0;
        wait_cyc(2);
        chk({pwm_off, crc_en, status}, 0);
        rst_n <= 1'b1;
        host.read_reg(`OFS_WDT_CTRL, d);
        chk(d, 0);
        wrap_up();
    end
endmodule : motor_ctrl_protect_status_regs_bench

//--- reg_host_model.sv
/*
 * Register master standing in for the external microcontroller.
 * Assumes the bank takes one-cycle strobes and answers a read one cycle
 * after the strobe edge.
 */
`include "motor_ctrl_map.svh"

module reg_host_model
    import motor_ctrl_pkg::*;
(
    input  wire logic       sys_clk_i, // System clock.
    input  wire logic [7:0] rdata_i,   // Read data from the bank.
    output reg_req_s        req_o      // Request strobes.
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req_o = '0;

    // Released lines show the inverse of the last value, so a bank that
    // samples them late sees garbage instead of a stale copy.
    task automatic release_bus();
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~req_o.addr,
                   wdata: ~req_o.wdata};
    endtask : release_bus

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk_i);
        release_bus();
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk_i);
        release_bus();
        @(posedge sys_clk_i);
        d = rdata_i;
    endtask : read_reg

    task automatic read_period(output logic [15:0] p);
        logic [7:0] hi;
        logic [7:0] lo;
        read_reg(`OFS_HP_HIGH, hi);
        read_reg(`OFS_HP_LOW, lo);
        p = {hi, lo};
    endtask : read_period

    task automatic clear_watchdog(input logic [1:0] per);
        write_reg(`OFS_WDT_CTRL, 8'h0c | {6'h00, per});
    endtask : clear_watchdog
endmodule : reg_host_model
